// ---- logic/lpm_regs.vh ----
// register offsets, field positions, reset values and event codes for the link packet monitor
`ifndef LPM_REGS_VH
`define LPM_REGS_VH
// register byte offsets (chosen map)
`define LPM_CTL0_OFF       12'h000
`define LPM_CTR0_LO_OFF    12'h040
`define LPM_MATCH_LO_OFF   12'h080
`define LPM_MATCH_HI_OFF   12'h084
`define LPM_MASK_LO_OFF    12'h088
`define LPM_MASK_HI_OFF    12'h08C
`define LPM_MATCH2_LO_OFF  12'h090
`define LPM_MATCH2_HI_OFF  12'h094
`define LPM_MASK2_LO_OFF   12'h098
`define LPM_MASK2_HI_OFF   12'h09C
`define LPM_STATUS_OFF     12'h0A0
// control register strides: ctl n at CTL0 + 4n, counter n at CTR0 + 8n (lo) / +4 (hi)
// control fields
`define LPM_EVSEL_MSB      7
`define LPM_CLEAR_BIT      17
`define LPM_OVEN_BIT       20
`define LPM_EN_BIT         22
`define LPM_CTL_MASK       32'h005000FF
// event codes
`define LPM_EV_FILTER0     8'h38
`define LPM_EV_FILTER1     8'h39
// counter width
`define LPM_CNT_W          48
// writable bits of match/mask words
`define LPM_HI_MASK        32'h000F000F
`define LPM_LO_MASK        32'h8003FFF8
`define LPM_RESET_VAL      32'h00000000
`endif

// ---- logic/lpm_packet_filter.v ----
// one match/mask packet filter pair
`timescale 1ns/1ps
module lpm_packet_filter (
  ref_clk,
  rst_n,
  pktValid,
  pktForward,
  pktLo,
  pktHi,
  matchLo,
  matchHi,
  maskLo,
  maskHi,
  hit
);
  input             ref_clk;
  input             rst_n;
  input             pktValid;   // packet present this cycle
  input             pktForward; // packet crosses input to output port
  input      [31:0] pktLo;      // packet fields in lower-word layout
  input      [31:0] pktHi;      // packet fields in upper-word layout
  input      [31:0] matchLo;
  input      [31:0] matchHi;
  input      [31:0] maskLo;
  input      [31:0] maskHi;
  output reg        hit;        // registered one-cycle match pulse

  wire loEq; // masked lower word agrees
  wire hiEq; // masked upper word agrees

  assign loEq = ((pktLo ^ matchLo) & maskLo) == 32'h00000000;
  assign hiEq = ((pktHi ^ matchHi) & maskHi) == 32'h00000000;

  // match only forwarded packets
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      hit <= 1'b0;
    end else begin
      hit <= pktValid & pktForward & loEq & hiEq;
    end
  end
endmodule

// ---- logic/lpm_port_monitor.v ----
// link port performance monitor: four 48-bit counters and two packet filters on apb
`timescale 1ns/1ps
`include "lpm_regs.vh"
// Operation
// - four 48-bit read/write event counters
// - overflow when carry leaves bit 47
// - counter wraps through zero, keeps counting
// - reads return live count, counting continues
// - upper sixteen bits read zero, reset zero
// - two match/mask pairs per port
// - only forwarded packets are filtered
// - filter hits count only with codes 0x38, 0x39
// - filter on opcode, class, state, node, address
// - upper match holds one-hot response state
// - remote node split: hi[3:0], lo[31]
// - lower match: destination, class, opcode fields
// - bypass/data classes: opcode top bit size
// - two-bit virtual network field, 1x shared
// - overflow with enable sets status, message
// - eight-bit event selector per counter
// - write-one clear bit zeroes counter
module lpm_port_monitor #(
  parameter NUM_CNT = 4,
  parameter CNT_W   = `LPM_CNT_W
) (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        pktValid,
  input  wire        pktForward,
  input  wire [31:0] pktLo,
  input  wire [31:0] pktHi,
  input  wire [7:0]  portEvents,
  output reg         overflowMsg,
  output reg  [3:0]  overflowCnt
);
  reg  [31:0]      ctl_reg [0:NUM_CNT-1];   // per-counter control
  reg  [CNT_W-1:0] cnt_reg [0:NUM_CNT-1];   // event counters
  reg  [31:0]      matchLo_reg [0:1];       // lower match words
  reg  [31:0]      matchHi_reg [0:1];       // upper match words
  reg  [31:0]      maskLo_reg  [0:1];       // lower mask words
  reg  [31:0]      maskHi_reg  [0:1];       // upper mask words
  reg  [3:0]       ovStatus_reg;            // sticky overflow flags
  wire [1:0]       filterHit;               // registered filter hits
  wire             acc;                     // apb access phase
  wire             wr;                      // apb write strobe
  reg  [31:0]      rdata_next;              // read mux
  reg              rerr_next;               // unmapped address
  reg  [3:0]       ovSet;                   // overflow this cycle
  integer          i;                       // loop index, register process
  integer          j;                       // loop index, read mux
  integer          k;                       // loop index, overflow detect

  // register map seen from the apb side, byte addresses
  // 0x000 control of counter 0
  // 0x004 control of counter 1
  // 0x008 control of counter 2
  // 0x00C control of counter 3
  // 0x040 counter 0, count bits 31:0
  // 0x044 counter 0, count bits 47:32 in the low half
  // 0x048 counter 1, low word
  // 0x04C counter 1, high word
  // 0x050 counter 2, low word
  // 0x054 counter 2, high word
  // 0x058 counter 3, low word
  // 0x05C counter 3, high word
  // 0x080 filter 0 lower match word
  // 0x084 filter 0 upper match word
  // 0x088 filter 0 lower mask word
  // 0x08C filter 0 upper mask word
  // 0x090 filter 1 lower match word
  // 0x094 filter 1 upper match word
  // 0x098 filter 1 lower mask word
  // 0x09C filter 1 upper mask word
  // 0x0A0 sticky overflow flags, one per counter
  // any other address answers with an error
  // an erroring write changes nothing
  // an erroring read returns zero
  //
  // control word layout
  // bits 7:0 pick the event to count
  // bit 17 clears the count, never stored
  // bit 20 lets an overflow raise a message
  // bit 22 lets the counter run at all
  // every other control bit reads zero
  //
  // event codes
  // 0x00 to 0x07 pick one generic port event
  // 0x38 picks the filter 0 hit pulse
  // 0x39 picks the filter 1 hit pulse
  // any other code counts nothing
  //
  // counting
  // one increment per cycle at most
  // reads never stall or pause the counter
  // the high half reads its top sixteen bits as zero
  // a carry out of bit 47 is an overflow
  // the count wraps to zero and keeps going
  // stopping after n events is left to software:
  // preload two to the 48th minus n, enable overflow
  //
  // write priority
  // a software write beats a same-cycle increment
  // the clear bit beats a same-cycle increment
  // halves of a counter are written one at a time
  // so a carry between halves may land mid-update
  // software should stop the counter before a preload
  //
  // overflow flags
  // set by hardware, cleared by writing one
  // a set in the same cycle as a clear wins
  // the message pulse lasts one cycle
  // the which-counter pulse lasts the same cycle
  //
  // filter timing
  // a packet is sampled on the edge it is valid
  // the hit pulse stands one cycle later
  // the selected counter moves on the next edge
  // so a counter trails its packet by two edges
  // packets not crossing to an output are ignored
  //
  // apb timing
  // the setup edge latches read data and pready
  // pready stands for the access cycle only
  // the access edge performs a write
  // no wait states are ever inserted

  assign acc = psel & penable;
  assign wr  = acc & pwrite;

  // selected event level for a counter
  function evHit;
    input [7:0] sel;
    input [1:0] fh;
    input [7:0] pe;
    begin
      if (sel == `LPM_EV_FILTER0)
        evHit = fh[0];
      else if (sel == `LPM_EV_FILTER1)
        evHit = fh[1];
      else if (sel < 8'h08)
        evHit = pe[sel[2:0]];
      else
        evHit = 1'b0;
    end
  endfunction

  // two filters per port
  lpm_packet_filter u_filt0 (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .pktValid   (pktValid),
    .pktForward (pktForward),
    .pktLo      (pktLo),
    .pktHi      (pktHi),
    .matchLo    (matchLo_reg[0]),
    .matchHi    (matchHi_reg[0]),
    .maskLo     (maskLo_reg[0]),
    .maskHi     (maskHi_reg[0]),
    .hit        (filterHit[0])
  );
  lpm_packet_filter u_filt1 (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .pktValid   (pktValid),
    .pktForward (pktForward),
    .pktLo      (pktLo),
    .pktHi      (pktHi),
    .matchLo    (matchLo_reg[1]),
    .matchHi    (matchHi_reg[1]),
    .maskLo     (maskLo_reg[1]),
    .maskHi     (maskHi_reg[1]),
    .hit        (filterHit[1])
  );

  // counters, control, filter registers and status
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      for (i = 0; i < NUM_CNT; i = i + 1) begin
        ctl_reg[i] <= `LPM_RESET_VAL;
        cnt_reg[i] <= {CNT_W{1'b0}};
      end
      for (i = 0; i < 2; i = i + 1) begin
        matchLo_reg[i] <= `LPM_RESET_VAL;
        matchHi_reg[i] <= `LPM_RESET_VAL;
        maskLo_reg[i]  <= `LPM_RESET_VAL;
        maskHi_reg[i]  <= `LPM_RESET_VAL;
      end
      ovStatus_reg <= 4'h0;
      overflowMsg  <= 1'b0;
      overflowCnt  <= 4'h0;
    end else begin
      for (i = 0; i < NUM_CNT; i = i + 1) begin
        // counting: live, wraps through zero
        if (ctl_reg[i][`LPM_EN_BIT] &&
            evHit(ctl_reg[i][`LPM_EVSEL_MSB:0], filterHit, portEvents)) begin
          cnt_reg[i] <= cnt_reg[i] + {{(CNT_W-1){1'b0}}, 1'b1};
        end
        // software writes win over the increment
        if (wr && paddr == `LPM_CTL0_OFF + 4 * i) begin
          ctl_reg[i] <= pwdata & `LPM_CTL_MASK;
          if (pwdata[`LPM_CLEAR_BIT])
            cnt_reg[i] <= {CNT_W{1'b0}};
        end
        if (wr && paddr == `LPM_CTR0_LO_OFF + 8 * i)
          cnt_reg[i][31:0] <= pwdata;
        if (wr && paddr == `LPM_CTR0_LO_OFF + 8 * i + 4)
          cnt_reg[i][CNT_W-1:32] <= pwdata[CNT_W-33:0];
      end
      for (i = 0; i < 2; i = i + 1) begin
        if (wr && paddr == `LPM_MATCH_LO_OFF + 16 * i)
          matchLo_reg[i] <= pwdata & `LPM_LO_MASK;
        if (wr && paddr == `LPM_MATCH_HI_OFF + 16 * i)
          matchHi_reg[i] <= pwdata & `LPM_HI_MASK;
        if (wr && paddr == `LPM_MASK_LO_OFF + 16 * i)
          maskLo_reg[i] <= pwdata & `LPM_LO_MASK;
        if (wr && paddr == `LPM_MASK_HI_OFF + 16 * i)
          maskHi_reg[i] <= pwdata & `LPM_HI_MASK;
      end
      // sticky status: set wins over write-one clear
      if (wr && paddr == `LPM_STATUS_OFF)
        ovStatus_reg <= (ovStatus_reg & ~pwdata[3:0]) | ovSet;
      else
        ovStatus_reg <= ovStatus_reg | ovSet;
      overflowMsg <= |ovSet;
      overflowCnt <= ovSet;
    end
  end

  // overflow detect: carry out of the top count bit
  always @* begin
    ovSet = 4'h0;
    for (k = 0; k < NUM_CNT; k = k + 1) begin
      if (ctl_reg[k][`LPM_EN_BIT] && ctl_reg[k][`LPM_OVEN_BIT] && (&cnt_reg[k]) &&
          evHit(ctl_reg[k][`LPM_EVSEL_MSB:0], filterHit, portEvents)) begin
        ovSet[k] = 1'b1;
      end
    end
  end

  // read mux, live counter values
  always @* begin
    rdata_next = 32'h00000000;
    rerr_next  = 1'b1;
    for (j = 0; j < NUM_CNT; j = j + 1) begin
      if (paddr == `LPM_CTL0_OFF + 4 * j) begin
        rdata_next = ctl_reg[j];
        rerr_next  = 1'b0;
      end else if (paddr == `LPM_CTR0_LO_OFF + 8 * j) begin
        rdata_next = cnt_reg[j][31:0];
        rerr_next  = 1'b0;
      end else if (paddr == `LPM_CTR0_LO_OFF + 8 * j + 4) begin
        rdata_next = {16'h0000, cnt_reg[j][CNT_W-1:32]};
        rerr_next  = 1'b0;
      end
    end
    for (j = 0; j < 2; j = j + 1) begin
      if (paddr == `LPM_MATCH_LO_OFF + 16 * j) begin
        rdata_next = matchLo_reg[j];
        rerr_next  = 1'b0;
      end else if (paddr == `LPM_MATCH_HI_OFF + 16 * j) begin
        rdata_next = matchHi_reg[j];
        rerr_next  = 1'b0;
      end else if (paddr == `LPM_MASK_LO_OFF + 16 * j) begin
        rdata_next = maskLo_reg[j];
        rerr_next  = 1'b0;
      end else if (paddr == `LPM_MASK_HI_OFF + 16 * j) begin
        rdata_next = maskHi_reg[j];
        rerr_next  = 1'b0;
      end
    end
    if (paddr == `LPM_STATUS_OFF) begin
      rdata_next = {28'h0000000, ovStatus_reg};
      rerr_next  = 1'b0;
    end
  end

  // apb answer: one wait-free access phase, registered
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & rerr_next;
      if (psel & ~penable & ~pwrite)
        prdata <= rdata_next;
    end
  end
endmodule

// ---- verif/lpm_port_monitor_sva.sv ----
// bus and overflow assertions for the link port monitor
`timescale 1ns/1ps
module lpm_port_monitor_sva (
  input wire        ref_clk,
  input wire        rst_n,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        overflowMsg,
  input wire [3:0]  overflowCnt
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_ready_setup: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
  a_ready_cause: assert property (pready |-> $past(psel) && !$past(penable)) else $error("stray ready");
  a_idle_quiet: assert property (!psel [*2] |-> !pready) else $error("ready while idle");
  a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_err_data: assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("error read data");
  a_ovf_which: assert property (overflowMsg |-> overflowCnt != 4'h0) else $error("message without counter");
  a_ovf_idle: assert property (!overflowMsg |-> overflowCnt == 4'h0) else $error("counter without message");
  a_reset_quiet: assert property (disable iff (1'b0) !rst_n |=> !pready && !overflowMsg && !overflowCnt)
    else $error("outputs active in reset");
  // main scenarios reached
  c_read: cover property (pready && !pwrite);
  c_write: cover property (pready && pwrite);
  c_refused: cover property (pslverr);
  c_overflow: cover property (overflowMsg);
endmodule
bind lpm_port_monitor lpm_port_monitor_sva sva_chk (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr), .overflowMsg(overflowMsg),
  .overflowCnt(overflowCnt));

// ---- verif/lpm_pkt_source.sv ----
// packet source standing in for the link layer forwarding path
`timescale 1ns/1ps
module lpm_pkt_source (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire        start,      // load a burst
  input  wire [7:0]  cnt,        // packets in burst, at least one
  input  wire        fwd,        // burst crosses input to output port
  input  wire [31:0] lo,
  input  wire [31:0] hi,
  output reg         pktValid,
  output reg         pktForward,
  output reg  [31:0] pktLo,
  output reg  [31:0] pktHi
);
  reg [7:0] left; // packets still owed
  // back-to-back packets; fields scrambled between bursts
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      left <= 8'h00;
      pktValid <= 1'b0;
    end else if (start) begin
      left <= cnt - 8'h01;
      pktValid <= 1'b1;
      pktForward <= fwd;
      pktLo <= lo;
      pktHi <= hi;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end else begin
      pktValid <= 1'b0;
      pktForward <= ~pktForward;
      pktLo <= ~pktLo;
      pktHi <= ~pktHi;
    end
  end
endmodule

// ---- verif/tb.sv ----
// self-checking bench for the link port monitor
`timescale 1ns/1ps
module tb;
  typedef struct {logic w; logic [11:0] a; logic [31:0] d, x; logic e;} lpm_row_t;
  logic        ref_clk, rst_n, psel, penable, pwrite, start, fwd, pready, pslverr, e;
  logic        pktValid, pktForward, overflowMsg;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, lo, hi, r, pktLo, pktHi;
  logic [3:0]  overflowCnt, ovfWhich;
  logic [7:0]  cnt, portEv;
  int          err_count = 0, n_checks = 0, cyc = 0, ovfSeen = 0;
  // reset values, writable bits, refused address
  lpm_row_t rows[14] = '{'{0, 12'h080, 0, 32'h0, 0}, '{0, 12'h044, 0, 32'h0, 0},
    '{1, 12'h084, 32'hFFFFFFFF, 0, 0}, '{0, 12'h084, 0, 32'h000F000F, 0},
    '{1, 12'h080, 32'hFFFFFFFF, 0, 0}, '{0, 12'h080, 0, 32'h8003FFF8, 0},
    '{1, 12'h044, 32'hFFFFFFFF, 0, 0}, '{0, 12'h044, 0, 32'h0000FFFF, 0},
    '{1, 12'h000, 32'hFFFFFFFF, 0, 0}, '{0, 12'h000, 0, 32'h005000FF, 0},
    '{1, 12'h094, 32'hFFFFFFFF, 0, 0}, '{0, 12'h094, 0, 32'h000F000F, 0},
    '{1, 12'h0FC, 32'h1, 0, 1}, '{0, 12'h0FC, 0, 32'h0, 1}};
  // filter 0 on data-response class in modified state, counter 0 preloaded three short of wrap
  logic [11:0] cfgA[8] = '{12'h080, 12'h088, 12'h084, 12'h08C, 12'h004, 12'h040, 12'h044, 12'h000};
  logic [31:0] cfgD[8] = '{32'h00001C00, 32'h00001E00, 32'h00080000, 32'h000F0000, 32'h00400000,
    32'hFFFFFFFD, 32'h0000FFFF, 32'h00500038};
  lpm_port_monitor dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pktValid(pktValid),
    .pktForward(pktForward), .pktLo(pktLo), .pktHi(pktHi), .portEvents(portEv), .overflowMsg(overflowMsg),
    .overflowCnt(overflowCnt));
  lpm_pkt_source src (.ref_clk(ref_clk), .rst_n(rst_n), .start(start), .cnt(cnt), .fwd(fwd), .lo(lo), .hi(hi),
    .pktValid(pktValid), .pktForward(pktForward), .pktLo(pktLo), .pktHi(pktHi));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // hang guard and overflow message capture
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (overflowMsg === 1'b1) begin
      ovfSeen++;
      ovfWhich = overflowCnt;
    end
    if (cyc == 5000) begin
      err_count++;
      summarize;
    end
  end
  task chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // one apb transfer, held until ready is sampled
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1 && ++t < 20);
    if (t == 20) err_count++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdchk(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask
  // burst of data-response packets with the given upper word
  task send(input logic [7:0] n, input logic f, input logic [31:0] h);
    @(posedge ref_clk);
    start <= 1'b1;
    cnt <= n;
    fwd <= f;
    lo <= 32'h00001C00;
    hi <= h;
    @(posedge ref_clk);
    start <= 1'b0;
    repeat (n + 4) @(posedge ref_clk);
  endtask
  task summarize;
    $display("checks=%0d errors=%0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, start, cnt, fwd, lo, hi, portEv} = '0;
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk(e, rows[i].e);
      if (!rows[i].w) chk(r, rows[i].x);
    end
    foreach (cfgA[i]) apb(1'b1, cfgA[i], cfgD[i]);
    send(8'd2, 1'b0, 32'h00080000);
    send(8'd1, 1'b1, 32'h00040000);
    rdchk(12'h040, 32'hFFFFFFFD);
    send(8'd3, 1'b1, 32'h00080000);
    rdchk(12'h040, 32'h0);
    rdchk(12'h044, 32'h0);
    chk(ovfSeen, 32'h1);
    chk(ovfWhich, 32'h1);
    rdchk(12'h0A0, 32'h1);
    send(8'd2, 1'b1, 32'h00080000);
    rdchk(12'h040, 32'h2);
    rdchk(12'h048, 32'h0);
    apb(1'b1, 12'h000, 32'h00520038);
    rdchk(12'h040, 32'h0);
    apb(1'b1, 12'h0A0, 32'h1);
    rdchk(12'h0A0, 32'h0);
    // generic event 3 on counter 2 for exactly five cycles
    apb(1'b1, 12'h008, 32'h00400003);
    portEv <= 8'h08;
    repeat (5) @(posedge ref_clk);
    portEv <= 8'h00;
    rdchk(12'h050, 32'h5);
    // filter 1 with an empty mask counts every forwarded packet on counter 3
    apb(1'b1, 12'h00C, 32'h00400039);
    send(8'd2, 1'b1, 32'h00080000);
    rdchk(12'h058, 32'h2);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rdchk(12'h000, 32'h0);
    rdchk(12'h050, 32'h0);
    summarize;
  end
endmodule
